//--- pia_pkg.sv
// Package of register map, bit positions and reset values for the adapter
package pia_pkg;
	// Register byte offsets; each side has a stride of three words
	localparam logic [4:0] OFS_DATA = 5'h00;
	localparam logic [4:0] OFS_DIR = 5'h04;
	localparam logic [4:0] OFS_CTL = 5'h08;
	localparam logic [4:0] SIDE_STRIDE = 5'h0C;
	localparam int ADDR_W = 5;
	localparam int PORT_W = 8;
	// Control register fields
	localparam int CB_IN1_EN = 0;
	localparam int CB_IN1_POL = 1;
	localparam int CB_L2_EN = 3;
	localparam int CB_L2_POL = 4;
	localparam int CB_L2_OUT = 5;
	localparam int CB_FLAG2 = 6;
	localparam int CB_FLAG1 = 7;
	localparam int CTL_WR_W = 6;
	// Line 2 output mode codes in control bits 5..3
	localparam logic [2:0] L2_HANDSHAKE = 3'h4;
	localparam logic [2:0] L2_PULSE = 3'h5;
	// Synchroniser layout: port A, port B, first lines, second lines
	localparam int SY_W = 20;
	localparam int SY_PB = 8;
	localparam int SY_IN1 = 16;
	localparam int SY_LN2 = 18;
	// Reset values
	localparam logic [7:0] RST_CTL = 8'h00;
	localparam logic [7:0] RST_PORT = 8'h00;
	localparam logic RST_LN2 = 1'b1;
	localparam logic [31:0] RST_RDATA = 32'h0000_0000;

	// Byte address of one register of one side
	function automatic logic [4:0] pia_addr(input logic side,
		input logic [4:0] ofs);
		pia_addr = (side ? SIDE_STRIDE : 5'h00) + ofs;
	endfunction : pia_addr

	// Qualified input edge in the selected direction
	function automatic logic pia_edge(input logic rise_sel,
		input logic old_v, input logic new_v);
		pia_edge = (old_v != new_v) && (new_v == rise_sel);
	endfunction : pia_edge
endpackage : pia_pkg

//--- pia_ctrl.sv
// Peripheral adapter core: two ports, control lines, Avalon-MM registers
//
// Behaviour
// - Two independent 8-bit bidirectional ports, side A and side B.
// - Every port line is set to input or output by software.
// - Four control lines, two per side, for interrupts or handshakes.
// - Active first-line edge sets control bit 7, whatever bit 0 is.
// - Bit 0 high: interrupt low while bit 7 set; bit 0 low: bit 7 does not drive it.
// - Bit 5 low: second line is input; bit 4 picks its edge.
// - In input mode an active second-line edge sets bit 6.
// - Input mode with bit 3 high: interrupt low while bit 6 set.
// - Side A mode 100: line high on first-line edge, low on A read.
// - Side A mode 101: line pulses low one cycle after A read.
// - Side B mode 100: line low on B write, high on first-line edge.
// - Bits 5,4 both high: line level follows control bit 3.
`timescale 1ns/1ns
module pia_ctrl
	import pia_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [7:0] port_side_a_in,
	output logic [7:0] port_side_a_out,
	output logic [7:0] port_side_a_oe,
	input wire logic [7:0] port_side_b_in,
	output logic [7:0] port_side_b_out,
	output logic [7:0] port_side_b_oe,
	input wire logic side_a_ctl_in1,
	input wire logic side_b_ctl_in1,
	input wire logic side_a_ctl_line2_in,
	output logic side_a_ctl_line2_out,
	output logic side_a_ctl_line2_oe,
	input wire logic side_b_ctl_line2_in,
	output logic side_b_ctl_line2_out,
	output logic side_b_ctl_line2_oe,
	output logic side_a_int_n,
	output logic side_b_int_n
);

	logic [SY_W-1:0] sy1_reg, sy2_reg, sy3_reg, stab_reg;
	logic [SY_W-1:0] stab_next;
	logic ack_reg, ack_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [7:0] ctl_reg [2];
	logic [7:0] ctl_next [2];
	logic [7:0] data_reg [2];
	logic [7:0] data_next [2];
	logic [7:0] dir_reg [2];
	logic [7:0] dir_next [2];
	logic [1:0] ln2_reg, ln2_next;
	logic [1:0] int_n_reg, int_n_next;
	logic [1:0] e1, e2, rd_data, wr_data;
	logic [7:0] pin_val [2];
	logic wr_go, rd_go, wr_lo;

	// Pin synchronisers; a change counts once stages two and three agree
	always_comb begin
		stab_next = (sy3_reg & ~(sy2_reg ^ sy3_reg)) |
			(stab_reg & (sy2_reg ^ sy3_reg));
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sy1_reg <= '0;
			sy2_reg <= '0;
			sy3_reg <= '0;
			stab_reg <= '0;
		end else begin
			sy1_reg <= {side_b_ctl_line2_in, side_a_ctl_line2_in,
				side_b_ctl_in1, side_a_ctl_in1,
				port_side_b_in, port_side_a_in};
			sy2_reg <= sy1_reg;
			sy3_reg <= sy2_reg;
			stab_reg <= stab_next;
		end
	end

	assign pin_val[0] = stab_reg[PORT_W-1:0];
	assign pin_val[1] = stab_reg[SY_PB+PORT_W-1:SY_PB];

	// Avalon slave: one wait cycle, then the access completes
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
	assign wr_go = avs_write & ack_reg;
	assign rd_go = avs_read & ack_reg;
	assign wr_lo = wr_go & avs_byteenable[0];

	always_comb begin
		ack_next = (avs_read | avs_write) & ~ack_reg;
		rdata_next = rdata_reg;
		if (avs_read && !ack_reg) begin
			rdata_next = RST_RDATA; // unmapped reads as zero
			for (int s = 0; s < 2; s++) begin
				if (avs_address == pia_addr(s[0], OFS_DATA))
					rdata_next[7:0] = (data_reg[s] & dir_reg[s]) |
						(pin_val[s] & ~dir_reg[s]);
				if (avs_address == pia_addr(s[0], OFS_DIR))
					rdata_next[7:0] = dir_reg[s];
				if (avs_address == pia_addr(s[0], OFS_CTL))
					rdata_next[7:0] = ctl_reg[s];
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_reg <= 1'b0;
			rdata_reg <= RST_RDATA;
		end else begin
			ack_reg <= ack_next;
			rdata_reg <= rdata_next;
		end
	end

	assign avs_readdata = rdata_reg;

	// Per-side flags, ports, second-line output and interrupt
	always_comb begin
		for (int s = 0; s < 2; s++) begin
			ctl_next[s] = ctl_reg[s];
			data_next[s] = data_reg[s];
			dir_next[s] = dir_reg[s];
			ln2_next[s] = ln2_reg[s];
			e1[s] = pia_edge(ctl_reg[s][CB_IN1_POL],
				stab_reg[SY_IN1+s], stab_next[SY_IN1+s]);
			e2[s] = ~ctl_reg[s][CB_L2_OUT] &
				pia_edge(ctl_reg[s][CB_L2_POL],
				stab_reg[SY_LN2+s], stab_next[SY_LN2+s]);
			rd_data[s] = rd_go &&
				avs_address == pia_addr(s[0], OFS_DATA);
			wr_data[s] = wr_lo &&
				avs_address == pia_addr(s[0], OFS_DATA);
			if (wr_data[s])
				data_next[s] = avs_writedata[7:0];
			if (wr_lo && avs_address == pia_addr(s[0], OFS_DIR))
				dir_next[s] = avs_writedata[7:0];
			if (wr_lo && avs_address == pia_addr(s[0], OFS_CTL))
				ctl_next[s][CTL_WR_W-1:0] =
					avs_writedata[CTL_WR_W-1:0];
			// Set wins over the clear by a data read
			ctl_next[s][CB_FLAG1] = e1[s] |
				(ctl_reg[s][CB_FLAG1] & ~rd_data[s]);
			ctl_next[s][CB_FLAG2] = e2[s] |
				(ctl_reg[s][CB_FLAG2] & ~rd_data[s]);
			unique casez (ctl_reg[s][CB_L2_OUT:CB_L2_EN])
				3'b0??: ln2_next[s] = RST_LN2;
				L2_HANDSHAKE: begin
					if (e1[s])
						ln2_next[s] = 1'b1;
					else if (s == 0 ? rd_data[s] : wr_data[s])
						ln2_next[s] = 1'b0;
				end
				L2_PULSE: begin
					ln2_next[s] = ~(s == 0 ? rd_data[s] : wr_data[s]);
				end
				3'b11?: ln2_next[s] = ctl_reg[s][CB_L2_EN];
			endcase
			int_n_next[s] = ~((ctl_reg[s][CB_FLAG1] &
				ctl_reg[s][CB_IN1_EN]) |
				(ctl_reg[s][CB_FLAG2] & ctl_reg[s][CB_L2_EN] &
				~ctl_reg[s][CB_L2_OUT]));
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int s = 0; s < 2; s++) begin
				ctl_reg[s] <= RST_CTL;
				data_reg[s] <= RST_PORT;
				dir_reg[s] <= RST_PORT;
			end
			ln2_reg <= {2{RST_LN2}};
			int_n_reg <= 2'b11;
		end else begin
			for (int s = 0; s < 2; s++) begin
				ctl_reg[s] <= ctl_next[s];
				data_reg[s] <= data_next[s];
				dir_reg[s] <= dir_next[s];
			end
			ln2_reg <= ln2_next;
			int_n_reg <= int_n_next;
		end
	end

	// Pin drivers
	assign port_side_a_out = data_reg[0];
	assign port_side_a_oe = dir_reg[0];
	assign port_side_b_out = data_reg[1];
	assign port_side_b_oe = dir_reg[1];
	assign side_a_ctl_line2_out = ln2_reg[0];
	assign side_b_ctl_line2_out = ln2_reg[1];
	assign side_a_ctl_line2_oe = ctl_reg[0][CB_L2_OUT];
	assign side_b_ctl_line2_oe = ctl_reg[1][CB_L2_OUT];
	assign side_a_int_n = int_n_reg[0];
	assign side_b_int_n = int_n_reg[1];

	// Checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	sequence seq_rd_a;
		rd_data[0] && !e1[0];
	endsequence

	sequence seq_wr_b;
		wr_data[1] && !e1[1];
	endsequence

	AST_DIR_OE: assert property (
		wr_lo && avs_address == pia_addr(1'b0, OFS_DIR)
		|=> port_side_a_oe == $past(avs_writedata[7:0]))
		else $error("port A enable does not follow direction write");

	AST_EDGE_RISE: assert property (
		ctl_reg[0][CB_IN1_POL] && !stab_reg[SY_IN1]
		&& stab_next[SY_IN1] |=> ctl_reg[0][CB_FLAG1])
		else $error("rising first-line edge missed");

	AST_EDGE_FALL_B: assert property (
		!ctl_reg[1][CB_IN1_POL] && stab_reg[SY_IN1+1]
		&& !stab_next[SY_IN1+1] |=> ctl_reg[1][CB_FLAG1])
		else $error("falling first-line edge missed on side B");

	AST_INT_ON: assert property (
		ctl_reg[0][CB_FLAG1] && ctl_reg[0][CB_IN1_EN]
		|=> !side_a_int_n)
		else $error("side A interrupt not asserted");

	AST_INT_OFF: assert property (
		!ctl_reg[1][CB_IN1_EN] && !ctl_reg[1][CB_L2_EN]
		|=> side_b_int_n)
		else $error("side B interrupt asserted while disabled");

	AST_FLAG2: assert property (
		!ctl_reg[0][CB_L2_OUT] && ctl_reg[0][CB_L2_POL]
		&& !stab_reg[SY_LN2] && stab_next[SY_LN2]
		|=> ctl_reg[0][CB_FLAG2])
		else $error("second-line edge did not set flag");

	AST_INT2: assert property (
		ctl_reg[1][CB_FLAG2] && ctl_reg[1][CB_L2_EN]
		&& !ctl_reg[1][CB_L2_OUT] |=> !side_b_int_n)
		else $error("side B second-line interrupt missing");

	AST_HS_A: assert property (
		ctl_reg[0][5:3] == L2_HANDSHAKE and seq_rd_a
		|=> !side_a_ctl_line2_out)
		else $error("side A handshake line not lowered on read");

	AST_PULSE_A: assert property (
		(ctl_reg[0][5:3] == L2_PULSE && rd_data[0]) ##1
		(!rd_data[0] && ctl_reg[0][5:3] == L2_PULSE)
		|-> !side_a_ctl_line2_out ##1 side_a_ctl_line2_out)
		else $error("side A pulse not one cycle low");

	AST_HS_B: assert property (
		ctl_reg[1][5:3] == L2_HANDSHAKE and seq_wr_b
		|=> !side_b_ctl_line2_out)
		else $error("side B handshake line not lowered on write");

	AST_MANUAL: assert property (
		ctl_reg[0][5:4] == 2'b11
		|=> side_a_ctl_line2_out == $past(ctl_reg[0][CB_L2_EN]))
		else $error("manual output does not follow bit 3");

	AST_CLR: assert property (
		seq_rd_a and !e2[0]
		|=> !ctl_reg[0][CB_FLAG1] && !ctl_reg[0][CB_FLAG2])
		else $error("data read did not clear flags");

	AST_BUS: assert property (
		avs_waitrequest |=> !avs_waitrequest)
		else $error("waitrequest held more than one cycle");

endmodule : pia_ctrl

//--- pia_periph.sv
// Peripheral model for one side: port pins and second control line
`timescale 1ns/1ns
module pia_periph (
	input wire logic [7:0] drv,
	input wire logic [7:0] out,
	input wire logic [7:0] oe,
	output logic [7:0] pin,
	input wire logic l2_drv,
	input wire logic l2_out,
	input wire logic l2_oe,
	output logic l2_pin
);
	// Resolved pin levels, adapter wins where it drives
	assign pin = (oe & out) | (~oe & drv);
	assign l2_pin = l2_oe ? l2_out : l2_drv;
endmodule : pia_periph

//--- tb.sv
// Testbench for the adapter: bus, ports and control lines
`timescale 1ns/1ns
module tb;
	import pia_pkg::*;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [7:0] pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe, rdat;
	logic [7:0] pa_drv = 8'h00;
	logic [7:0] pb_drv = 8'h00;
	logic [3:0] lv = 4'h0;
	logic l2a_in, l2a_out, l2a_oe, l2b_in, l2b_out, l2b_oe, ia_n, ib_n;
	int n_mismatch = 0;
	int compares = 0;
	// Clock
	always #5 core_clk = ~core_clk;
	// Adapter and the two peripheral sides
	pia_ctrl pia_ctrl_inst (.core_clk(core_clk), .rst_n(rst_n),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .port_side_a_in(pa_in),
		.port_side_a_out(pa_out), .port_side_a_oe(pa_oe),
		.port_side_b_in(pb_in), .port_side_b_out(pb_out),
		.port_side_b_oe(pb_oe), .side_a_ctl_in1(lv[0]),
		.side_b_ctl_in1(lv[2]), .side_a_ctl_line2_in(l2a_in),
		.side_a_ctl_line2_out(l2a_out), .side_a_ctl_line2_oe(l2a_oe),
		.side_b_ctl_line2_in(l2b_in), .side_b_ctl_line2_out(l2b_out),
		.side_b_ctl_line2_oe(l2b_oe), .side_a_int_n(ia_n),
		.side_b_int_n(ib_n));
	pia_periph pia_periph_inst (.drv(pa_drv), .out(pa_out), .oe(pa_oe),
		.pin(pa_in), .l2_drv(lv[1]), .l2_out(l2a_out), .l2_oe(l2a_oe),
		.l2_pin(l2a_in));
	pia_periph pia_periph_b_inst (.drv(pb_drv), .out(pb_out), .oe(pb_oe),
		.pin(pb_in), .l2_drv(lv[3]), .l2_out(l2b_out), .l2_oe(l2b_oe),
		.l2_pin(l2b_in));
	task wrap_up;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up
	task chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// One Avalon-MM transfer, held until waitrequest is low
	task bus(input logic w, input logic [4:0] a, input logic [7:0] d,
		input logic [3:0] be);
		int i;
		@(posedge core_clk);
		avs_read <= ~w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_byteenable <= be;
		for (i = 0; i < 20; i++) begin
			@(posedge core_clk);
			if (avs_waitrequest === 1'b0) break;
		end
		rdat = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (i == 20) begin
			n_mismatch++;
			wrap_up();
		end
	endtask : bus
	task rd(input logic [4:0] a);
		bus(1'b0, a, 8'h00, 4'h0);
	endtask : rd
	task wr(input logic [4:0] a, input logic [7:0] d);
		bus(1'b1, a, d, 4'hF);
	endtask : wr
	task hold;
		repeat (7) @(posedge core_clk);
	endtask : hold
	// Move one control line, then let the synchroniser settle
	task setl(input logic [1:0] k, input logic v);
		@(posedge core_clk);
		lv[k] <= v;
		hold();
	endtask : setl
	// Edge select, flag and interrupt of one control line
	task edge_t(input logic s, input logic ln, input logic p, input logic e);
		logic [4:0] b;
		logic [7:0] c;
		logic [7:0] f;
		b = s ? SIDE_STRIDE : 5'h00;
		c = ln ? {3'h0, p, e, 3'h0} : {6'h00, p, e};
		f = ln ? 8'h40 : 8'h80;
		wr(b + OFS_CTL, c);
		setl({s, ln}, p);
		rd(b + OFS_DATA);
		setl({s, ln}, ~p);
		rd(b + OFS_CTL);
		chk(rdat, c);
		chk({7'h0, (s ? l2b_oe : l2a_oe)}, 8'h00);
		setl({s, ln}, p);
		rd(b + OFS_CTL);
		chk(rdat, c | f);
		chk({7'h0, s ? ib_n : ia_n}, {7'h0, ~e});
		rd(b + OFS_DATA);
		rd(b + OFS_CTL);
		chk(rdat, c);
		chk({7'h0, s ? ib_n : ia_n}, 8'h01);
	endtask : edge_t
	// Main sequence
	initial begin
		logic [4:0] b;
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		for (int a = 0; a <= 24; a += 4) begin
			rd(a[4:0]);
			chk(rdat, RST_CTL);
			chk(avs_readdata[15:8], 8'h00);
		end
		chk({6'h0, l2a_out, l2b_out}, 8'h03);
		chk({6'h0, ia_n, ib_n}, 8'h03);
		pa_drv <= 8'h3C;
		pb_drv <= 8'h3C;
		for (int s = 0; s < 2; s++) begin
			b = s[0] ? SIDE_STRIDE : 5'h00;
			wr(b + OFS_DIR, 8'hF0);
			wr(b + OFS_DATA, 8'hA5);
			bus(1'b1, b + OFS_DATA, 8'h11, 4'h0);
			hold();
			rd(b + OFS_DATA);
			chk(rdat, 8'hAC);
			rd(b + OFS_DIR);
			chk(rdat, 8'hF0);
			chk(s[0] ? pb_oe : pa_oe, 8'hF0);
			chk(s[0] ? pb_out : pa_out, 8'hA5);
			wr(b + OFS_CTL, 8'hFF);
			rd(b + OFS_CTL);
			chk(rdat, 8'h3F);
			hold();
			chk({7'h0, (s[0] ? l2b_out : l2a_out)}, 8'h01);
			chk({7'h0, (s[0] ? l2b_oe : l2a_oe)}, 8'h01);
			wr(b + OFS_CTL, 8'h30);
			hold();
			chk({7'h0, (s[0] ? l2b_out : l2a_out)}, 8'h00);
		end
		wr(5'h18, 8'hFF);
		rd(5'h18);
		chk(rdat, 8'h00);
		for (int k = 0; k < 16; k++)
			edge_t(k[3], k[2], k[1], k[0]);
		setl(2'd0, 1'b0);
		wr(OFS_CTL, 8'h22);
		rd(OFS_DATA);
		hold();
		chk({7'h0, l2a_out}, 8'h00);
		setl(2'd0, 1'b1);
		chk({7'h0, l2a_out}, 8'h01);
		wr(OFS_CTL, 8'h28);
		rd(OFS_DATA);
		@(negedge core_clk);
		chk({7'h0, l2a_out}, 8'h00);
		@(negedge core_clk);
		chk({7'h0, l2a_out}, 8'h01);
		setl(2'd2, 1'b0);
		wr(SIDE_STRIDE + OFS_CTL, 8'h22);
		wr(SIDE_STRIDE + OFS_DATA, 8'h00);
		@(negedge core_clk);
		chk({7'h0, l2b_out}, 8'h00);
		setl(2'd2, 1'b1);
		chk({7'h0, l2b_out}, 8'h01);
		// Side B pulse mode: one low cycle after a data write
		wr(SIDE_STRIDE + OFS_CTL, 8'h28);
		wr(SIDE_STRIDE + OFS_DATA, 8'h00);
		@(negedge core_clk);
		chk({7'h0, l2b_out}, 8'h00);
		@(negedge core_clk);
		chk({7'h0, l2b_out}, 8'h01);
		wrap_up();
	end
endmodule : tb
